//--- hdl/sfpe_pkg.sv
// Shared opcodes, sizes, timing and state encodings of the program/erase sequencer.
package sfpe_pkg;
	localparam logic [7:0] OP_PROG_A4   = 8'h12;
	localparam logic [7:0] OP_QPROG     = 8'h32;
	localparam logic [7:0] OP_QPROG_A4  = 8'h34;
	localparam logic [7:0] OP_SECT      = 8'h20;
	localparam logic [7:0] OP_SECT_A4   = 8'h21;
	localparam logic [7:0] OP_BLK32     = 8'h52;
	localparam logic [7:0] OP_BLK64     = 8'hd8;
	localparam logic [7:0] OP_BLK64_A4  = 8'hdc;
	localparam logic [5:0] OP_BITS      = 6'h08;
	localparam logic [5:0] ADDR3_BITS   = 6'h18;
	localparam logic [5:0] ADDR4_BITS   = 6'h20;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [8:0] PAGE_BYTES   = 9'h100;
	localparam logic [31:0] SECT_BYTES  = 32'h0000_1000;
	localparam logic [31:0] BLK32_BYTES = 32'h0000_8000;
	localparam logic [31:0] BLK64_BYTES = 32'h0001_0000;
	localparam int BLK_LSB              = 16;
	localparam int BLK_W                = 9;
	localparam logic [9:0] DIE_BLOCKS   = 10'h200;
	localparam logic [3:0] BP_ALL       = 4'ha;
	localparam int CLK_MHZ              = 100;
	localparam int SECTOR_ERASE_TIME_US      = 200;
	localparam int SMALL_BLOCK_ERASE_TIME_US = 400;
	localparam int LARGE_BLOCK_ERASE_TIME_US = 600;
	localparam int PAGE_PROGRAM_TIME_US      = 20;
	localparam int SECTOR_ERASE_CYC      = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int SMALL_BLOCK_ERASE_CYC = SMALL_BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int LARGE_BLOCK_ERASE_CYC = LARGE_BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int PAGE_PROGRAM_CYC      = PAGE_PROGRAM_TIME_US * CLK_MHZ;
	typedef enum logic [2:0] {
		PH_OP   = 3'h1,
		PH_ADDR = 3'h2,
		PH_DATA = 3'h4
	} sfpe_phase_t;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_CHECK = 4'h2,
		ST_PROG  = 4'h4,
		ST_WAIT  = 4'h8
	} sfpe_state_t;
endpackage

//--- hdl/sfpe_frame_if.sv
// Frame results handed from the serial-clock front end to the core.
interface sfpe_frame_if;
	logic [7:0]  op;
	logic [31:0] addr;
	logic [8:0]  nbytes;
	logic        ends_ok;
	logic [7:0]  rd_col;
	logic [7:0]  rd_data;
	logic        addr4;
	modport link (output op, addr, nbytes, ends_ok, rd_data, input rd_col, addr4);
	modport core (input op, addr, nbytes, ends_ok, rd_data, output rd_col, addr4);
endinterface

//--- hdl/sfpe_timer.sv
// Countdown that times the self-timed program and erase periods.
module sfpe_timer #(
	parameter int W = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_cycles,
	output logic              o_done
);
	typedef struct packed {
		logic         run;
		logic [W-1:0] cnt;
	} sfpe_tmr_t;
	sfpe_tmr_t tmr_reg;
	sfpe_tmr_t tmr_next;

	always_comb begin
		tmr_next = tmr_reg;
		if (i_load) begin
			tmr_next.run = 1'b1;
			tmr_next.cnt = i_cycles;
		end else if (tmr_reg.run) begin
			tmr_next.cnt = tmr_reg.cnt - 1'b1;
			if (tmr_reg.cnt == W'(1)) begin
				tmr_next.run = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	assign o_done = tmr_reg.run && (tmr_reg.cnt == W'(1));
endmodule

//--- hdl/sfpe_link.sv
// Serial-clock front end: shifts opcode, address and page data into a page buffer.
module sfpe_link (
	input  wire logic       i_spi_sck,
	input  wire logic       i_spi_cs_n,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_quad_line,
	sfpe_frame_if.link      frm
);
	typedef struct packed {
		logic [2:0]  ph;
		logic [5:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  op;
		logic [31:0] addr;
		logic [7:0]  col;
		logic [8:0]  nbytes;
		logic        ends_ok;
	} sfpe_link_t;
	sfpe_link_t lnk_reg;
	sfpe_link_t lnk_next;
	logic       live_reg;
	logic       wr_en;
	logic [7:0] wr_byte;
	logic [7:0] page_mem [256];

	always_comb begin
		logic       four;
		logic       quad;
		logic [5:0] abits;
		logic [5:0] step;
		logic [7:0] nsh;
		four = 1'b0;
		quad = 1'b0;
		abits = 6'h00;
		step = 6'h00;
		nsh = 8'h00;
		lnk_next = lnk_reg;
		wr_en = 1'b0;
		wr_byte = 8'h00;
		// The first edge after select falls restarts parsing; results survive select high.
		if (!live_reg) begin
			lnk_next.ph = sfpe_pkg::PH_OP;
			lnk_next.cnt = 6'h00;
			lnk_next.addr = 32'h0000_0000;
			lnk_next.nbytes = 9'h000;
		end
		lnk_next.ends_ok = 1'b0;
		four = frm.addr4;
		if (lnk_next.op == sfpe_pkg::OP_PROG_A4 || lnk_next.op == sfpe_pkg::OP_QPROG_A4 ||
			lnk_next.op == sfpe_pkg::OP_SECT_A4 || lnk_next.op == sfpe_pkg::OP_BLK64_A4) begin
			four = 1'b1;
		end
		quad = (lnk_next.op == sfpe_pkg::OP_QPROG) || (lnk_next.op == sfpe_pkg::OP_QPROG_A4);
		abits = four ? sfpe_pkg::ADDR4_BITS : sfpe_pkg::ADDR3_BITS;
		step = quad ? 6'h04 : 6'h01;
		nsh = quad ? {lnk_next.sh[3:0], i_quad_line} : {lnk_next.sh[6:0], i_quad_line[0]};
		case (lnk_next.ph)
			sfpe_pkg::PH_OP: begin
				lnk_next.op = {lnk_next.op[6:0], i_quad_line[0]};
				lnk_next.cnt = lnk_next.cnt + 6'h01;
				if (lnk_next.cnt == sfpe_pkg::OP_BITS) begin
					lnk_next.ph = sfpe_pkg::PH_ADDR;
					lnk_next.cnt = 6'h00;
				end
			end
			sfpe_pkg::PH_ADDR: begin
				lnk_next.addr = {lnk_next.addr[30:0], i_quad_line[0]};
				lnk_next.cnt = lnk_next.cnt + 6'h01;
				if (lnk_next.cnt == abits) begin
					lnk_next.ph = sfpe_pkg::PH_DATA;
					lnk_next.cnt = 6'h00;
					lnk_next.col = lnk_next.addr[7:0];
					lnk_next.ends_ok = 1'b1;
				end
			end
			sfpe_pkg::PH_DATA: begin
				lnk_next.sh = nsh;
				lnk_next.cnt = lnk_next.cnt + step;
				if (lnk_next.cnt == 6'(sfpe_pkg::BYTE_BITS)) begin
					wr_en = 1'b1;
					wr_byte = nsh;
					lnk_next.cnt = 6'h00;
					lnk_next.col = lnk_next.col + 8'h01;
					lnk_next.ends_ok = 1'b1;
					if (lnk_next.nbytes != sfpe_pkg::PAGE_BYTES) begin
						lnk_next.nbytes = lnk_next.nbytes + 9'h001;
					end
				end
			end
			default: begin
				lnk_next.ph = sfpe_pkg::PH_OP;
			end
		endcase
	end

	always_ff @(posedge i_spi_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// Parsing waits for an opcode even before the select flag has once seen select high.
			lnk_reg <= '0;
			lnk_reg.ph <= sfpe_pkg::PH_OP;
		end else begin
			lnk_reg <= lnk_next;
		end
	end

	always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
		if (i_spi_cs_n) begin
			live_reg <= 1'b0;
		end else begin
			live_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_spi_sck) begin
		if (wr_en) begin
			page_mem[lnk_reg.col] <= wr_byte;
		end
	end

	assign frm.op = lnk_reg.op;
	assign frm.addr = lnk_reg.addr;
	assign frm.nbytes = lnk_reg.nbytes;
	assign frm.ends_ok = lnk_reg.ends_ok;
	assign frm.rd_data = page_mem[frm.rd_col];
endmodule

//--- hdl/sfpe_top.sv
// Program and erase sequencer of one serial NOR flash die.
// Operation
// - Opcode 12h always takes a 32-bit address.
// - Opcode 34h always takes a 32-bit address.
// - Opcode 21h always takes a 32-bit address.
// - Opcode DCh always takes a 32-bit address.
// - Opcodes 32h, 20h, 52h, D8h take 24 or 32 bits by address mode.
// - One program takes at most one 256-byte page.
// - Program and erase are refused unless the write enable latch is set.
// - Quad program otherwise behaves like single-line page program.
// - Sector erase sets its 4 KB sector to all ones.
// - 32 KB block erase sets its block to all ones.
// - 64 KB block erase sets its block to all ones.
// - Erase runs only if select rises right after the last address bit.
// - A valid erase starts a self-timed erase needing no host clocks.
// - Busy reads one for the whole operation, zero at completion.
// - Finished erase clears the write enable latch.
// - Erase is skipped when protect field or lock covers the target.
// - Data past the page end wraps to the start of the page.
// - Program runs only if select rises right after a whole data byte.
module sfpe_top #(
	parameter int P_SECTOR_ERASE_CYC      = sfpe_pkg::SECTOR_ERASE_CYC,
	parameter int P_SMALL_BLOCK_ERASE_CYC = sfpe_pkg::SMALL_BLOCK_ERASE_CYC,
	parameter int P_LARGE_BLOCK_ERASE_CYC = sfpe_pkg::LARGE_BLOCK_ERASE_CYC,
	parameter int P_PAGE_PROGRAM_CYC      = sfpe_pkg::PAGE_PROGRAM_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_spi_sck,
	input  wire logic        i_spi_cs_n,
	input  wire logic [3:0]  i_quad_line,
	input  wire logic        i_addr_mode_4byte,
	input  wire logic        i_write_enable_latch,
	input  wire logic        i_protect_complement,
	input  wire logic        i_protect_top_bottom,
	input  wire logic        i_protect_field_bit3,
	input  wire logic        i_protect_field_bit2,
	input  wire logic        i_protect_field_bit1,
	input  wire logic        i_protect_field_bit0,
	input  wire logic        i_target_locked,
	output logic [31:0]      o_lock_query_addr,
	output logic             o_busy,
	output logic             o_wel_clear,
	output logic             o_cmd_rejected,
	output logic             o_arr_erase,
	output logic [31:0]      o_arr_erase_bytes,
	output logic             o_arr_prog,
	output logic [31:0]      o_arr_addr,
	output logic [7:0]       o_arr_data
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		sfpe_pkg::sfpe_state_t st;
		logic                  cs_s1;
		logic                  cs_s2;
		logic                  cs_s3;
		logic                  is_prog;
		logic [31:0]           addr;
		logic [31:0]           size;
		logic [31:0]           cyc;
		logic [8:0]            nbytes;
		logic [8:0]            cnt;
		logic [7:0]            col;
		logic                  busy;
		logic                  wel_clr;
		logic                  rej;
		logic                  erase;
		logic                  prog;
		logic [31:0]           arr_addr;
		logic [7:0]            arr_data;
		logic                  tload;
	} sfpe_core_t;
	sfpe_core_t core_reg;
	sfpe_core_t core_next;
	logic       tmr_done;
	logic [3:0] bp;

	sfpe_frame_if frm ();

	sfpe_link u_link (
		.i_spi_sck   (i_spi_sck),
		.i_spi_cs_n  (i_spi_cs_n),
		.i_rst_n     (i_rst_n),
		.i_quad_line (i_quad_line),
		.frm         (frm.link)
	);

	sfpe_timer #(
		.W (32)
	) u_timer (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_load   (core_reg.tload),
		.i_cycles (core_reg.cyc),
		.o_done   (tmr_done)
	);

	// The address mode must stay still while a frame is being clocked in.
	assign frm.addr4 = i_addr_mode_4byte;
	assign frm.rd_col = core_reg.col;
	assign bp = {i_protect_field_bit3, i_protect_field_bit2,
		i_protect_field_bit1, i_protect_field_bit0};

	////////////////////////////////////////////////////////////////////////////////
	// Every erase and program stays inside one 64 KB block, so the block index decides.
	function automatic logic prot_hit(input logic [31:0] a, input logic [3:0] f,
		input logic tb, input logic cmp);
		logic [9:0] nblk;
		logic [9:0] idx;
		logic       hit;
		nblk = 10'h000;
		if (f >= sfpe_pkg::BP_ALL) begin
			nblk = sfpe_pkg::DIE_BLOCKS;
		end else if (f != 4'h0) begin
			nblk = 10'h001 << (f - 4'h1);
		end
		idx = {1'b0, a[sfpe_pkg::BLK_LSB +: sfpe_pkg::BLK_W]};
		if (tb) begin
			hit = idx < nblk;
		end else begin
			hit = idx >= (sfpe_pkg::DIE_BLOCKS - nblk);
		end
		return hit ^ cmp;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic cs_rise;
		logic known;
		logic erase_op;
		logic prog_op;
		cs_rise = 1'b0;
		known = 1'b0;
		erase_op = 1'b0;
		prog_op = 1'b0;
		core_next = core_reg;
		core_next.cs_s1 = i_spi_cs_n;
		core_next.cs_s2 = core_reg.cs_s1;
		core_next.cs_s3 = core_reg.cs_s2;
		core_next.wel_clr = 1'b0;
		core_next.rej = 1'b0;
		core_next.erase = 1'b0;
		core_next.prog = 1'b0;
		core_next.tload = 1'b0;
		// Frame results are read only after select is seen high, when the serial clock is still.
		cs_rise = core_reg.cs_s2 && !core_reg.cs_s3;
		case (frm.op)
			sfpe_pkg::OP_PROG_A4,
			sfpe_pkg::OP_QPROG,
			sfpe_pkg::OP_QPROG_A4: begin
				prog_op = 1'b1;
			end
			sfpe_pkg::OP_SECT,
			sfpe_pkg::OP_SECT_A4: begin
				erase_op = 1'b1;
				core_next.size = sfpe_pkg::SECT_BYTES;
				core_next.cyc = 32'(P_SECTOR_ERASE_CYC);
			end
			sfpe_pkg::OP_BLK32: begin
				erase_op = 1'b1;
				core_next.size = sfpe_pkg::BLK32_BYTES;
				core_next.cyc = 32'(P_SMALL_BLOCK_ERASE_CYC);
			end
			sfpe_pkg::OP_BLK64,
			sfpe_pkg::OP_BLK64_A4: begin
				erase_op = 1'b1;
				core_next.size = sfpe_pkg::BLK64_BYTES;
				core_next.cyc = 32'(P_LARGE_BLOCK_ERASE_CYC);
			end
			default: begin
				known = 1'b0;
			end
		endcase
		known = erase_op || prog_op;
		if (!known || core_reg.st != sfpe_pkg::ST_IDLE) begin
			core_next.size = core_reg.size;
			core_next.cyc = core_reg.cyc;
		end
		case (core_reg.st)
			sfpe_pkg::ST_IDLE: begin
				if (cs_rise && known) begin
					if (erase_op && frm.ends_ok && frm.nbytes == 9'h000) begin
						core_next.st = sfpe_pkg::ST_CHECK;
						core_next.is_prog = 1'b0;
						core_next.addr = frm.addr;
					end else if (prog_op && frm.ends_ok && frm.nbytes != 9'h000) begin
						core_next.st = sfpe_pkg::ST_CHECK;
						core_next.is_prog = 1'b1;
						core_next.addr = frm.addr;
						core_next.nbytes = frm.nbytes;
						core_next.cyc = 32'(P_PAGE_PROGRAM_CYC);
					end else begin
						core_next.rej = 1'b1;
					end
				end
			end
			sfpe_pkg::ST_CHECK: begin
				// The lock lookup has had one cycle to answer for the held address.
				if (!i_write_enable_latch) begin
					core_next.rej = 1'b1;
					core_next.st = sfpe_pkg::ST_IDLE;
				end else if (i_target_locked || prot_hit(core_reg.addr, bp,
					i_protect_top_bottom, i_protect_complement)) begin
					core_next.rej = 1'b1;
					core_next.st = sfpe_pkg::ST_IDLE;
				end else if (core_reg.is_prog) begin
					core_next.busy = 1'b1;
					core_next.st = sfpe_pkg::ST_PROG;
					core_next.cnt = 9'h000;
					core_next.col = core_reg.addr[7:0];
				end else begin
					core_next.busy = 1'b1;
					core_next.erase = 1'b1;
					core_next.arr_addr = core_reg.addr & ~(core_reg.size - 32'h1);
					core_next.tload = 1'b1;
					core_next.st = sfpe_pkg::ST_WAIT;
				end
			end
			sfpe_pkg::ST_PROG: begin
				// One buffered byte per cycle, walking the page from the start column.
				core_next.prog = 1'b1;
				core_next.arr_addr = {core_reg.addr[31:8], core_reg.col};
				core_next.arr_data = frm.rd_data;
				core_next.col = core_reg.col + 8'h01;
				core_next.cnt = core_reg.cnt + 9'h001;
				if (core_next.cnt == core_reg.nbytes) begin
					core_next.tload = 1'b1;
					core_next.st = sfpe_pkg::ST_WAIT;
				end
			end
			sfpe_pkg::ST_WAIT: begin
				if (tmr_done) begin
					core_next.busy = 1'b0;
					core_next.wel_clr = 1'b1;
					core_next.st = sfpe_pkg::ST_IDLE;
				end
			end
			default: begin
				core_next.st = sfpe_pkg::ST_IDLE;
				core_next.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			core_reg <= '0;
			core_reg.st <= sfpe_pkg::ST_IDLE;
			core_reg.cs_s1 <= 1'b1;
			core_reg.cs_s2 <= 1'b1;
			core_reg.cs_s3 <= 1'b1;
		end else begin
			core_reg <= core_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign o_lock_query_addr = core_reg.addr;
	assign o_busy = core_reg.busy;
	assign o_wel_clear = core_reg.wel_clr;
	assign o_cmd_rejected = core_reg.rej;
	assign o_arr_erase = core_reg.erase;
	assign o_arr_erase_bytes = core_reg.size;
	assign o_arr_prog = core_reg.prog;
	assign o_arr_addr = core_reg.arr_addr;
	assign o_arr_data = core_reg.arr_data;
endmodule

//--- dv/sfpe_checker.sv
// Concurrent checks on the ports of the program/erase sequencer.
module sfpe_checker #(
	parameter int P_SECTOR_ERASE_CYC      = 20,
	parameter int P_SMALL_BLOCK_ERASE_CYC = 30,
	parameter int P_LARGE_BLOCK_ERASE_CYC = 40
) (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_write_enable_latch,
	input wire logic        o_busy,
	input wire logic        o_wel_clear,
	input wire logic        o_cmd_rejected,
	input wire logic        o_arr_erase,
	input wire logic [31:0] o_arr_erase_bytes,
	input wire logic        o_arr_prog,
	input wire logic [31:0] o_arr_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned cnt_reg;
	int unsigned need_reg;
	////////////////////////////////////////////////////////////////
	// Busy length is counted here because it far exceeds any repetition count.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= 0;
			need_reg <= 0;
		end else begin
			cnt_reg <= o_busy ? cnt_reg + 1 : 0;
			if (o_arr_erase)
				need_reg <= (o_arr_erase_bytes == 32'h0000_1000) ? P_SECTOR_ERASE_CYC :
					(o_arr_erase_bytes == 32'h0000_8000) ? P_SMALL_BLOCK_ERASE_CYC :
					P_LARGE_BLOCK_ERASE_CYC;
			else if (o_arr_prog)
				need_reg <= 0;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	a_erase_size_legal: assert property (o_arr_erase |->
		o_arr_erase_bytes inside {32'h0000_1000, 32'h0000_8000, 32'h0001_0000})
		else $error("erase size not a sector or block");
	a_erase_base_aligned: assert property (o_arr_erase |->
		(o_arr_addr & (o_arr_erase_bytes - 32'h1)) == 32'h0)
		else $error("erase base not aligned");
	a_erase_needs_wel: assert property (o_arr_erase |->
		i_write_enable_latch && o_busy)
		else $error("erase without latch or busy");
	a_reject_stays_idle: assert property (o_cmd_rejected |->
		!o_busy ##1 (!o_cmd_rejected && !o_busy))
		else $error("refused command went busy");
	a_wel_clear_fall: assert property (o_wel_clear |-> $fell(o_busy))
		else $error("latch clear away from completion");
	a_fall_wel_clear: assert property ($fell(o_busy) |-> o_wel_clear)
		else $error("completion without latch clear");
	a_prog_page_step: assert property (o_arr_prog && $past(o_arr_prog) |->
		o_arr_addr == {$past(o_arr_addr[31:8]), $past(o_arr_addr[7:0]) + 8'h01})
		else $error("program address left the page");
	a_prog_under_busy: assert property (o_arr_prog |-> o_busy)
		else $error("program byte outside busy");
	a_busy_erase_len: assert property ($fell(o_busy) && need_reg != 0 |->
		cnt_reg >= need_reg && cnt_reg <= need_reg + 3)
		else $error("erase busy length wrong");
endmodule

//--- dv/sfpe_host.sv
// Host controller model that clocks frames into the sequencer.
module sfpe_host (
	output logic       o_sck,
	output logic       o_cs_n,
	output logic [3:0] o_quad
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_quad = 4'h0;
	end
	// The clock only runs inside frames; idle lines flip so stale data never passes.
	task automatic put(input logic [3:0] v);
		o_quad = v;
		#3 o_sck = 1'b1;
		#3 o_sck = 1'b0;
	endtask
	task automatic bit1(input logic b);
		put({~o_quad[3:1], b});
	endtask
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, input int nb,
		input logic q, input int tl);
		logic [7:0] d;
		o_cs_n = 1'b0;
		#3;
		for (int i = 7; i >= 0; i--) bit1(op[i]);
		for (int i = ab - 1; i >= 0; i--) bit1(a[i]);
		for (int i = 0; i < nb; i++) begin
			d = 8'hc3 - 8'(i);
			if (q) begin
				put(d[7:4]);
				put(d[3:0]);
			end else begin
				for (int j = 7; j >= 0; j--) bit1(d[j]);
			end
		end
		for (int i = 0; i < tl; i++) bit1(1'b1);
		#3 o_cs_n = 1'b1;
		o_quad = ~o_quad;
		#60;
	endtask
endmodule

//--- dv/sfpe_top_tb.sv
// Self-checking bench of the program/erase sequencer.
module sfpe_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk, i_rst_n, mode4, write_enable_latch, cmp, tbot, lock, busy, wclr, rej, ers, prg, seen_busy;
	logic [3:0] bp;
	logic [31:0] esz, aadr, lqa, e_addr[$], e_size[$], p_addr[$];
	logic [7:0] adat, p_data[$];
	wire logic sck, cs_n;
	wire logic [3:0] quad;
	int n_errors, check_count, n_rej, n_wel;
	logic [7:0] ops [5] = '{8'h20, 8'h21, 8'h52, 8'hd8, 8'hdc};
	int ab [5] = '{24, 32, 24, 24, 32};
	logic [31:0] sz [5] = '{32'h1000, 32'h1000, 32'h8000, 32'h10000, 32'h10000};
	////////////////////////////////////////////////////////////////
	sfpe_host u_sfpe_host (.o_sck(sck), .o_cs_n(cs_n), .o_quad(quad));
	sfpe_top #(.P_SECTOR_ERASE_CYC(20), .P_SMALL_BLOCK_ERASE_CYC(30),
		.P_LARGE_BLOCK_ERASE_CYC(40), .P_PAGE_PROGRAM_CYC(10)) u_sfpe_top (
		.i_clk, .i_rst_n, .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_quad_line(quad),
		.i_addr_mode_4byte(mode4), .i_write_enable_latch(write_enable_latch), .i_protect_complement(cmp),
		.i_protect_top_bottom(tbot), .i_protect_field_bit3(bp[3]), .i_protect_field_bit2(bp[2]),
		.i_protect_field_bit1(bp[1]), .i_protect_field_bit0(bp[0]), .i_target_locked(lock),
		.o_lock_query_addr(lqa), .o_busy(busy), .o_wel_clear(wclr), .o_cmd_rejected(rej),
		.o_arr_erase(ers), .o_arr_erase_bytes(esz), .o_arr_prog(prg), .o_arr_addr(aadr),
		.o_arr_data(adat));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (ers === 1'b1) begin
			e_addr.push_back(aadr);
			e_size.push_back(esz);
		end
		if (prg === 1'b1) begin
			p_addr.push_back(aadr);
			p_data.push_back(adat);
		end
		if (rej === 1'b1) n_rej++;
		if (wclr === 1'b1) n_wel++;
		if (busy === 1'b1) seen_busy = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("mismatches %0d of %0d comparisons", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One frame, then a bounded wait until the self-timed period is over.
	task automatic run(input logic [7:0] op, input logic [31:0] a, input int abits, input int nb,
		input logic q, input int tl);
		int k;
		e_addr.delete();
		e_size.delete();
		p_addr.delete();
		p_data.delete();
		n_rej = 0;
		n_wel = 0;
		seen_busy = 1'b0;
		u_sfpe_host.frame(op, a, abits, nb, q, tl);
		repeat (8) @(posedge i_clk);
		for (k = 0; k < 500 && busy !== 1'b0; k++) @(posedge i_clk);
		if (k == 500) begin
			chk("busy end", 32'h0, {31'h0, busy});
			finish_test();
		end else begin
			repeat (2) @(posedge i_clk);
		end
	endtask
	task automatic exp_erase(input logic [31:0] a, input logic [31:0] s);
		chk("erase count", 32'h1, 32'(e_addr.size()));
		chk("erase base", a & ~(s - 32'h1), e_addr[0]);
		chk("erase size", s, e_size[0]);
		chk("busy seen", 32'h1, {31'h0, seen_busy});
		chk("latch clear", 32'h1, 32'(n_wel));
	endtask
	task automatic exp_prog(input logic [31:0] b, input int n);
		chk("prog count", 32'(n), 32'(p_addr.size()));
		for (int i = 0; i < n; i++) begin
			chk("prog addr", {b[31:8], b[7:0] + 8'(i)}, p_addr[i]);
			chk("prog data", {24'h0, 8'hc3 - 8'(i)}, {24'h0, p_data[i]});
		end
		chk("latch clear", 32'h1, 32'(n_wel));
	endtask
	task automatic exp_rej;
		chk("reject", 32'h1, 32'(n_rej));
		chk("busy seen", 32'h0, {31'h0, seen_busy});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{i_rst_n, mode4, cmp, tbot, lock, bp} = '0;
		write_enable_latch = 1'b1;
		repeat (8) @(posedge i_clk);
		chk("reset outputs", 32'h0, {27'h0, busy, wclr, rej, ers, prg});
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		for (int i = 0; i < 5; i++) begin
			run(ops[i], 32'h0012_3456, ab[i], 0, 1'b0, 0);
			exp_erase(32'h0012_3456, sz[i]);
		end
		mode4 <= 1'b1;
		run(8'h52, 32'h0123_4567, 32, 0, 1'b0, 0);
		exp_erase(32'h0123_4567, 32'h8000);
		run(8'h32, 32'h0000_30a0, 32, 1, 1'b1, 0);
		exp_prog(32'h0000_30a0, 1);
		mode4 <= 1'b0;
		run(8'h34, 32'h0000_10fe, 32, 3, 1'b1, 0);
		exp_prog(32'h0000_10fe, 3);
		run(8'h32, 32'h0000_2040, 24, 2, 1'b1, 0);
		exp_prog(32'h0000_2040, 2);
		run(8'h12, 32'h0001_00ff, 32, 2, 1'b0, 0);
		exp_prog(32'h0001_00ff, 2);
		run(8'h20, 32'h0012_3456, 23, 0, 1'b0, 0);
		exp_rej();
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 1);
		exp_rej();
		run(8'h32, 32'h0000_2040, 24, 1, 1'b1, 1);
		exp_rej();
		write_enable_latch <= 1'b0;
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		exp_rej();
		write_enable_latch <= 1'b1;
		bp <= 4'ha;
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		exp_rej();
		cmp <= 1'b1;
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		exp_erase(32'h0012_3456, 32'h1000);
		{cmp, tbot, bp} <= {1'b0, 1'b1, 4'h1};
		run(8'hd8, 32'h0000_1234, 24, 0, 1'b0, 0);
		exp_rej();
		run(8'hd8, 32'h0001_1234, 24, 0, 1'b0, 0);
		exp_erase(32'h0001_1234, 32'h10000);
		{tbot, bp, lock} <= {1'b0, 4'h0, 1'b1};
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		exp_rej();
		chk("lock query addr", 32'h0012_3456, lqa);
		lock <= 1'b0;
		// A reset in the middle of an erase must drop busy and leave the sequencer usable.
		u_sfpe_host.frame(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		@(posedge i_clk);
		chk("busy before reset", 32'h1, {31'h0, busy});
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("busy in reset", 32'h0, {31'h0, busy});
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		run(8'h20, 32'h0012_3456, 24, 0, 1'b0, 0);
		exp_erase(32'h0012_3456, 32'h1000);
		finish_test();
	end
endmodule
bind sfpe_top sfpe_checker #(.P_SECTOR_ERASE_CYC(P_SECTOR_ERASE_CYC),
	.P_SMALL_BLOCK_ERASE_CYC(P_SMALL_BLOCK_ERASE_CYC),
	.P_LARGE_BLOCK_ERASE_CYC(P_LARGE_BLOCK_ERASE_CYC)) u_sfpe_checker (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_write_enable_latch(i_write_enable_latch),
	.o_busy(o_busy), .o_wel_clear(o_wel_clear), .o_cmd_rejected(o_cmd_rejected),
	.o_arr_erase(o_arr_erase), .o_arr_erase_bytes(o_arr_erase_bytes),
	.o_arr_prog(o_arr_prog), .o_arr_addr(o_arr_addr));
